// File: design/tcsg_sound_alarm.sv
/*
 * Two-channel pseudo-random sound generator with alarm mode, as an
 * AXI4-Lite slave. Drives two buzzer pins or hands them back to GPIO.
 * Assumes the oscillator tick inputs are one-cycle pulses synchronous
 * to aclk, one per oscillator period.
 */
// How it works
// [RULE1] Channel one is a 7-bit shift counter seeded from its value registers.
// [RULE2] Channel two is a 15-bit counter: 15-bit noise or 7-bit tone.
// [RULE3] Per-channel mode bit: one selects noise, zero selects tone.
// [RULE4] Enable bits 0 and 1 gate channels one and two.
// [RULE5] Volume code 00 is silence; 01, 10, 11 give rising levels.
// [RULE6] Master off gives GPIO pins; on selects sound or alarm by alarm bit.
// [RULE7] Prescaler codes divide the 32 kHz sound clock by 1, 2, 4, 8.
// [RULE8] Source select picks slow oscillator at 0, fast at 1.
// [RULE9] Fast frequency bit picks 500k at 0, 262k at 1 division.
// [RULE10] The sound clock is 32 kHz whatever source is chosen.
// [RULE11] Tone half period is N prescaled ticks, N from 1 to 127.
// [RULE12] Seed 01 gives N of 127, down to seed 40 giving 1.
// [RULE13] Tone seeds: channel one bits 6..0, channel two bits 14..8.
// [RULE14] Values span nibble registers; top nibble bit 3 is the mode.
// [RULE15] Configuration registers are write-only; reads return zero.
// [RULE16] Alarm mode gives a fixed 4K or 2K carrier gated by envelope.
// [RULE17] Channel two low nibble is the envelope control; zero is DC.
// [RULE18] Envelope bits 0..3 pick 1, 2, 4, 8 Hz, combined by AND.
// [RULE19] Software disables the generator before entering stop mode.
// [RULE20] Software keeps the fast frequency bit true to the oscillator.
// [RULE21] Software avoids both channels playing the same tone.
// [RULE22] Seven-bit sequence shifts left, feedback bit 6 xor bit 5.
// [RULE23] Noise mode outputs the serial bit once per prescaled tick.
`timescale 1ns/1ps
`default_nettype none

module tcsg_sound_alarm #(
   parameter int ALARM_CARRIER_KHZ = 4,
   parameter int ADDR_W            = 12
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Oscillator ticks
   input  wire logic              slow_oscillator,
   input  wire logic              fast_oscillator,
   // Port logic used while pins are GPIO
   input  wire logic              gpio_a_out,
   input  wire logic              gpio_a_oe,
   input  wire logic              gpio_b_out,
   input  wire logic              gpio_b_oe,
   // Buzzer pins
   output logic                   sound_pin_a_o,
   output logic                   sound_pin_a_oe,
   output logic                   sound_pin_b_o,
   output logic                   sound_pin_b_oe
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (ALARM_CARRIER_KHZ != 4 && ALARM_CARRIER_KHZ != 2) begin : g_bad_carrier
      $error("ALARM_CARRIER_KHZ must be 4 or 2");
   end
   if (ADDR_W < 12) begin : g_bad_addr
      $error("ADDR_W must be at least 12");
   end

   // Carrier half period in sound ticks, less one
   localparam logic [2:0] CAR_HALF =
      3'((tcsg_pkg::SOUND_KHZ / ALARM_CARRIER_KHZ / 2) - 1);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [6:0]  c1_val;
      logic        c1_noise;
      logic [14:0] c2_val;
      logic        c2_noise;
      logic [1:0]  vol;
      logic [1:0]  ch_on;
      logic [1:0]  div1;
      logic [1:0]  div2;
      logic        sel;
      logic        fast_rc_freq_select;
      logic        alarm_on;
      logic        master_on;
      logic        aw_held;
      logic [9:0]  aw_idx;
      logic        w_held;
      logic [3:0]  w_nib;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [4:0]  fast_cnt;
      logic [2:0]  pre1;
      logic [2:0]  pre2;
      logic [6:0]  lfsr1;
      logic [14:0] lfsr2;
      logic        tone1;
      logic        tone2;
      logic        reload1;
      logic        reload2;
      logic [1:0]  vol_ph;
      logic [14:0] env_cnt;
      logic [2:0]  car_cnt;
      logic        carrier;
      logic        pin_a;
      logic        pin_b;
      logic        oe_a;
      logic        oe_b;
   } tcsg_state_s;

   tcsg_state_s st;
   tcsg_state_s next_st;

   // ---------------------------------------------------------------
   // Combinational next state
   // ---------------------------------------------------------------
   always_comb begin
      logic       do_wr;
      logic       snd_tick;
      logic       tick1;
      logic       tick2;
      logic [2:0] mask1;
      logic [2:0] mask2;
      logic [4:0] fast_div;
      logic       out1;
      logic       out2;
      logic       mix;
      logic       loud;
      logic       env;
      logic       alarm_sig;
      tcsg_pkg::tcsg_pin_fn_e pin_fn;

      next_st   = st;
      do_wr     = 1'b0;
      snd_tick  = 1'b0;
      tick1     = 1'b0;
      tick2     = 1'b0;
      mask1     = 3'h0;
      mask2     = 3'h0;
      fast_div  = tcsg_pkg::FAST500_DIV;
      out1      = 1'b0;
      out2      = 1'b0;
      mix       = 1'b0;
      loud      = 1'b0;
      env       = 1'b1;
      alarm_sig = 1'b0;
      pin_fn    = tcsg_pkg::TCSG_PIN_GPIO;

      // -------------------------------------------------------------
      // Bus: write address and data are taken in either order
      // -------------------------------------------------------------
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_idx  = s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_held  = 1'b1;
         next_st.w_nib   = s_axi_wdata[3:0];
         next_st.w_lane0 = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_held && st.w_held && !st.bvalid) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = tcsg_pkg::RESP_OKAY;
         do_wr           = st.w_lane0;
         // Status is read-only; writes to it are dropped quietly
         case (st.aw_idx)
            tcsg_pkg::IDX_CHAN1_VALUE_LOW,
            tcsg_pkg::IDX_CHAN1_VALUE_HIGH_MODE,
            tcsg_pkg::IDX_CHAN2_VALUE_N1_ALARM_ENV,
            tcsg_pkg::IDX_CHAN2_VALUE_N2,
            tcsg_pkg::IDX_CHAN2_VALUE_N3,
            tcsg_pkg::IDX_CHAN2_VALUE_N4_MODE,
            tcsg_pkg::IDX_VOLUME_AND_CHANNEL_EN,
            tcsg_pkg::IDX_CHANNEL_PRESCALERS,
            tcsg_pkg::IDX_CLOCK_SELECT_AND_ALARM,
            tcsg_pkg::IDX_SOUND_MASTER,
            tcsg_pkg::IDX_SOUND_STATUS: ;
            default: begin
               next_st.bresp = tcsg_pkg::RESP_DECERR;
               do_wr         = 1'b0;
            end
         endcase
      end

      if (do_wr) begin
         case (st.aw_idx)
            tcsg_pkg::IDX_CHAN1_VALUE_LOW: begin
               next_st.c1_val[3:0] = st.w_nib;                         // RULE14
               next_st.reload1     = 1'b1;
            end
            tcsg_pkg::IDX_CHAN1_VALUE_HIGH_MODE: begin
               next_st.c1_val[6:4] = st.w_nib[2:0];                    // RULE14
               next_st.c1_noise    = st.w_nib[tcsg_pkg::MODE_BIT];     // RULE3
               next_st.reload1     = 1'b1;
            end
            tcsg_pkg::IDX_CHAN2_VALUE_N1_ALARM_ENV: begin
               next_st.c2_val[3:0] = st.w_nib;                         // RULE17
               next_st.reload2     = 1'b1;
            end
            tcsg_pkg::IDX_CHAN2_VALUE_N2: begin
               next_st.c2_val[7:4] = st.w_nib;                         // RULE14
               next_st.reload2     = 1'b1;
            end
            tcsg_pkg::IDX_CHAN2_VALUE_N3: begin
               next_st.c2_val[11:8] = st.w_nib;                        // RULE14
               next_st.reload2      = 1'b1;
            end
            tcsg_pkg::IDX_CHAN2_VALUE_N4_MODE: begin
               next_st.c2_val[14:12] = st.w_nib[2:0];                  // RULE14
               next_st.c2_noise      = st.w_nib[tcsg_pkg::MODE_BIT];   // RULE3
               next_st.reload2       = 1'b1;
            end
            tcsg_pkg::IDX_VOLUME_AND_CHANNEL_EN: begin
               next_st.ch_on[0] = st.w_nib[tcsg_pkg::CHAN1_ON_BIT];    // RULE4
               next_st.ch_on[1] = st.w_nib[tcsg_pkg::CHAN2_ON_BIT];    // RULE4
               next_st.vol      = st.w_nib[tcsg_pkg::VOLUME_LSB_BIT +: 2];
            end
            tcsg_pkg::IDX_CHANNEL_PRESCALERS: begin
               next_st.div1 = st.w_nib[1:0];                           // RULE7
               next_st.div2 = st.w_nib[3:2];                           // RULE7
            end
            tcsg_pkg::IDX_CLOCK_SELECT_AND_ALARM: begin
               next_st.sel      = st.w_nib[tcsg_pkg::CLK_SEL_BIT];     // RULE8
               next_st.alarm_on = st.w_nib[tcsg_pkg::ALARM_ON_BIT];
               next_st.fast_rc_freq_select     = st.w_nib[tcsg_pkg::FAST_RC_FREQ_BIT]; // RULE9
            end
            tcsg_pkg::IDX_SOUND_MASTER: begin
               next_st.master_on = st.w_nib[tcsg_pkg::MASTER_ON_BIT];
            end
            default: ;
         endcase
      end

      // -------------------------------------------------------------
      // Bus: read, one cycle after the address is taken
      // -------------------------------------------------------------
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = 32'h0000_0000;                               // RULE15
         next_st.rresp  = tcsg_pkg::RESP_OKAY;
         case (s_axi_araddr[11:2])
            tcsg_pkg::IDX_SOUND_STATUS: begin
               next_st.rdata[5:0] = {st.oe_b, st.oe_a, st.pin_b, st.pin_a,
                                     st.master_on, st.alarm_on};
            end
            tcsg_pkg::IDX_CHAN1_VALUE_LOW,
            tcsg_pkg::IDX_CHAN1_VALUE_HIGH_MODE,
            tcsg_pkg::IDX_CHAN2_VALUE_N1_ALARM_ENV,
            tcsg_pkg::IDX_CHAN2_VALUE_N2,
            tcsg_pkg::IDX_CHAN2_VALUE_N3,
            tcsg_pkg::IDX_CHAN2_VALUE_N4_MODE,
            tcsg_pkg::IDX_VOLUME_AND_CHANNEL_EN,
            tcsg_pkg::IDX_CHANNEL_PRESCALERS,
            tcsg_pkg::IDX_CLOCK_SELECT_AND_ALARM,
            tcsg_pkg::IDX_SOUND_MASTER: ;                             // RULE15
            default: next_st.rresp = tcsg_pkg::RESP_DECERR;
         endcase
      end

      // -------------------------------------------------------------
      // 32 kHz sound clock from either oscillator
      // -------------------------------------------------------------
      fast_div = st.fast_rc_freq_select ? tcsg_pkg::FAST262_DIV : tcsg_pkg::FAST500_DIV;  // RULE9
      if (!st.sel) begin
         snd_tick         = slow_oscillator;                           // RULE8
         next_st.fast_cnt = 5'h00;
      end else if (fast_oscillator) begin
         if (st.fast_cnt >= fast_div - 5'h01) begin
            snd_tick         = 1'b1;                                   // RULE10
            next_st.fast_cnt = 5'h00;
         end else begin
            next_st.fast_cnt = st.fast_cnt + 5'h01;
         end
      end

      // -------------------------------------------------------------
      // Prescalers
      // -------------------------------------------------------------
      mask1 = 3'((4'h1 << st.div1) - 4'h1);
      mask2 = 3'((4'h1 << st.div2) - 4'h1);
      if (snd_tick) begin
         next_st.pre1 = st.pre1 + 3'h1;
         next_st.pre2 = st.pre2 + 3'h1;
         tick1        = (st.pre1 & mask1) == mask1;                    // RULE7
         tick2        = (st.pre2 & mask2) == mask2;                    // RULE7
      end

      // -------------------------------------------------------------
      // Channel one
      // -------------------------------------------------------------
      if (st.reload1) begin
         next_st.reload1 = 1'b0;
         next_st.lfsr1   = st.c1_noise ? tcsg_pkg::LFSR7_RESET : st.c1_val;  // RULE1
         next_st.tone1   = 1'b0;
      end else if (tick1) begin
         if (!st.c1_noise && st.lfsr1 == tcsg_pkg::SEED7_END) begin
            next_st.tone1 = ~st.tone1;                                 // RULE11
            next_st.lfsr1 = st.c1_val;                                 // RULE12
         end else if (st.lfsr1 == 7'h00) begin
            next_st.lfsr1 = tcsg_pkg::LFSR7_RESET;
         end else begin
            next_st.lfsr1 = {st.lfsr1[5:0], st.lfsr1[6] ^ st.lfsr1[5]};  // RULE22
         end
      end
      out1 = st.c1_noise ? st.lfsr1[6] : st.tone1;                     // RULE23

      // -------------------------------------------------------------
      // Channel two: low 7 bits run the tone, all 15 the noise
      // -------------------------------------------------------------
      if (st.reload2) begin
         next_st.reload2 = 1'b0;
         next_st.lfsr2   = st.c2_noise ? tcsg_pkg::LFSR15_RESET
                                       : {8'h00, st.c2_val[14:8]};     // RULE13
         next_st.tone2   = 1'b0;
      end else if (tick2) begin
         if (st.c2_noise) begin
            if (st.lfsr2 == 15'h0000) begin
               next_st.lfsr2 = tcsg_pkg::LFSR15_RESET;
            end else begin
               next_st.lfsr2 = {st.lfsr2[13:0], st.lfsr2[14] ^ st.lfsr2[13]};  // RULE2
            end
         end else if (st.lfsr2[6:0] == tcsg_pkg::SEED7_END) begin
            next_st.tone2 = ~st.tone2;                                 // RULE11
            next_st.lfsr2 = {8'h00, st.c2_val[14:8]};                  // RULE13
         end else if (st.lfsr2[6:0] == 7'h00) begin
            next_st.lfsr2 = {8'h00, tcsg_pkg::LFSR7_RESET};
         end else begin
            next_st.lfsr2 = {8'h00, st.lfsr2[5:0], st.lfsr2[6] ^ st.lfsr2[5]};  // RULE22
         end
      end
      out2 = st.c2_noise ? st.lfsr2[14] : st.tone2;                    // RULE23

      // Same tone on both channels cancels; software avoids it
      mix = (out1 & st.ch_on[0]) ^ (out2 & st.ch_on[1]);               // RULE4 RULE21

      // -------------------------------------------------------------
      // Volume: duty over three aclk phases, code 00 silent
      // -------------------------------------------------------------
      next_st.vol_ph = (st.vol_ph == 2'h2) ? 2'h0 : st.vol_ph + 2'h1;
      loud = st.vol_ph < st.vol;                                       // RULE5

      // -------------------------------------------------------------
      // Alarm carrier and envelope
      // -------------------------------------------------------------
      if (snd_tick) begin
         next_st.env_cnt = st.env_cnt + 15'h0001;
         if (st.car_cnt == CAR_HALF) begin
            next_st.car_cnt = 3'h0;
            next_st.carrier = ~st.carrier;                             // RULE16
         end else begin
            next_st.car_cnt = st.car_cnt + 3'h1;
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (st.c2_val[i]) begin
            env = env & st.env_cnt[tcsg_pkg::ENV_1HZ_BIT - i];         // RULE18
         end
      end
      alarm_sig = st.carrier & env;                                    // RULE16 RULE17

      // -------------------------------------------------------------
      // Pin function
      // -------------------------------------------------------------
      if (!st.master_on) begin
         pin_fn = tcsg_pkg::TCSG_PIN_GPIO;                             // RULE6
      end else if (st.alarm_on) begin
         pin_fn = tcsg_pkg::TCSG_PIN_ALARM;                            // RULE6
      end else begin
         pin_fn = tcsg_pkg::TCSG_PIN_SOUND;                            // RULE6
      end
      // Sound and alarm drive the pins in antiphase so a buzzer across them sees double swing; GPIO passes through
      case (pin_fn)
         tcsg_pkg::TCSG_PIN_SOUND: begin
            next_st.pin_a = mix & loud;
            next_st.pin_b = ~(mix & loud);
            next_st.oe_a  = 1'b1;
            next_st.oe_b  = 1'b1;
         end
         tcsg_pkg::TCSG_PIN_ALARM: begin
            next_st.pin_a = alarm_sig;
            next_st.pin_b = ~alarm_sig;
            next_st.oe_a  = 1'b1;
            next_st.oe_b  = 1'b1;
         end
         default: begin
            next_st.pin_a = gpio_a_out;
            next_st.pin_b = gpio_b_out;
            next_st.oe_a  = gpio_a_oe;
            next_st.oe_b  = gpio_b_oe;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st          <= '0;
         st.c2_val   <= tcsg_pkg::CHAN2_RESET;
         st.lfsr1    <= tcsg_pkg::LFSR7_RESET;
         st.lfsr2    <= tcsg_pkg::LFSR15_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign s_axi_awready  = !st.aw_held;
   assign s_axi_wready   = !st.w_held;
   assign s_axi_bvalid   = st.bvalid;
   assign s_axi_bresp    = st.bresp;
   assign s_axi_arready  = !st.rvalid;
   assign s_axi_rvalid   = st.rvalid;
   assign s_axi_rdata    = st.rdata;
   assign s_axi_rresp    = st.rresp;
   assign sound_pin_a_o  = st.pin_a;
   assign sound_pin_a_oe = st.oe_a;
   assign sound_pin_b_o  = st.pin_b;
   assign sound_pin_b_oe = st.oe_b;

endmodule

`default_nettype wire

// File: common/tcsg_pkg.sv
/*
 * Constants for the two-channel sound and alarm generator: register
 * indices, field positions, reset values and clock divisions.
 * Assumes a 32-bit AXI4-Lite bus, one register per aligned word at
 * byte address four times the register index.
 */
package tcsg_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_CHAN1_VALUE_LOW          = 10'h360;
   localparam logic [9:0] IDX_CHAN1_VALUE_HIGH_MODE    = 10'h361;
   localparam logic [9:0] IDX_CHAN2_VALUE_N1_ALARM_ENV = 10'h362;
   localparam logic [9:0] IDX_CHAN2_VALUE_N2           = 10'h363;
   localparam logic [9:0] IDX_CHAN2_VALUE_N3           = 10'h364;
   localparam logic [9:0] IDX_CHAN2_VALUE_N4_MODE      = 10'h365;
   localparam logic [9:0] IDX_VOLUME_AND_CHANNEL_EN    = 10'h366;
   localparam logic [9:0] IDX_CHANNEL_PRESCALERS       = 10'h367;
   localparam logic [9:0] IDX_CLOCK_SELECT_AND_ALARM   = 10'h368;
   localparam logic [9:0] IDX_SOUND_MASTER             = 10'h369;
   localparam logic [9:0] IDX_SOUND_STATUS             = 10'h36a;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MODE_BIT          = 3;
   localparam int CHAN1_ON_BIT      = 0;
   localparam int CHAN2_ON_BIT      = 1;
   localparam int VOLUME_LSB_BIT    = 2;
   localparam int CLK_SEL_BIT       = 0;
   localparam int ALARM_ON_BIT      = 1;
   localparam int FAST_RC_FREQ_BIT  = 2;
   localparam int MASTER_ON_BIT     = 0;

   // ---------------------------------------------------------------
   // Reset values and sequence constants
   // ---------------------------------------------------------------
   localparam logic [6:0]  SEED7_END      = 7'h40;
   localparam logic [6:0]  LFSR7_RESET    = 7'h01;
   localparam logic [14:0] LFSR15_RESET   = 15'h0001;
   localparam logic [14:0] CHAN2_RESET    = 15'h0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;

   // ---------------------------------------------------------------
   // Clock derivation: fast RC ticks per 32 kHz sound tick
   // ---------------------------------------------------------------
   localparam logic [4:0]  FAST500_DIV    = 5'h10;
   localparam logic [4:0]  FAST262_DIV    = 5'h08;
   localparam int          SOUND_KHZ      = 32;
   localparam int          ENV_CNT_W      = 15;
   localparam int          ENV_1HZ_BIT    = 14;

   // Pin function codes, internal only; the status register shows master and alarm bits
   typedef enum logic [1:0] {
      TCSG_PIN_GPIO  = 2'b00,
      TCSG_PIN_SOUND = 2'b01,
      TCSG_PIN_ALARM = 2'b10
   } tcsg_pin_fn_e;

endpackage

// File: verif/tcsg_sound_alarm_properties.sv
/* Handshake and write-only read checks bound to the sound generator.
   Assumes the top's AXI4-Lite ports and an active-low sync reset. */
`timescale 1ns/1ps
`default_nettype none
module tcsg_sound_alarm_properties #(parameter int ADDR_W = 12) (
   // Bus
   input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
   input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_pair;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready high after take");
   AST_W_HELD: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("wready high after take");
   AST_B_TIME: assert property (wr_pair |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   AST_CFG_WO: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[ADDR_W-1:2] inside {[10'h360:10'h368]} |=> s_axi_rdata == 32'h0)
      else $error("config read not zero");
endmodule
bind tcsg_sound_alarm tcsg_sound_alarm_properties #(.ADDR_W(ADDR_W))
   tcsg_sound_alarm_properties_inst (.*);
`default_nettype wire

// File: verif/tcsg_buzzer_model.sv
/* Buzzer across the sound pins: times the gaps between changes of pin a.
   Assumes a pull-down holds a released pin low. */
`timescale 1ns/1ps
`default_nettype none
module tcsg_buzzer_model (
   // Clock and pin
   input wire logic aclk, pin_a_o, pin_a_oe,
   // Last gap, change count
   output int       gap, flips
);
   logic last = 1'h0;
   int   cnt = 0, n = 0, g = 0;
   wire logic lvl = pin_a_oe & pin_a_o;
   assign gap = g;
   assign flips = n;
   always @(posedge aclk) begin
      last <= lvl;
      cnt <= (lvl !== last) ? 1 : cnt + 1;
      if (lvl !== last) begin
         g <= cnt;
         n <= n + 1;
      end
   end
endmodule
`default_nettype wire

// File: verif/tcsg_sound_alarm_test.sv
/* Bench: bus access, tones, silence, alarm and pin hand-over.
   Assumes the buzzer model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tcsg_sound_alarm_test;
   logic aclk = 0, aresetn = 0, slow_oscillator = 0, fast_oscillator = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, gpio_a_out = 1, gpio_a_oe = 1, gpio_b_out = 0, gpio_b_oe = 1;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic sound_pin_a_o, sound_pin_a_oe, sound_pin_b_o, sound_pin_b_oe;
   int   gap, flips, n_mismatch = 0, samples_checked = 0;
   tcsg_sound_alarm tcsg_sound_alarm_inst (.*);
   tcsg_buzzer_model tcsg_buzzer_model_inst (.aclk, .pin_a_o(sound_pin_a_o),
      .pin_a_oe(sound_pin_a_oe), .gap, .flips);
   initial forever #10 aclk = ~aclk;
   // Ticks every other cycle keep tone periods short
   always @(posedge aclk) slow_oscillator <= !slow_oscillator;
   always @(posedge aclk) fast_oscillator <= !fast_oscillator;
   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw = 1, w = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (aw | w) begin
         @(negedge aclk);
         aw &= !s_axi_awready;
         w &= !s_axi_wready;
         @(posedge aclk);
         {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
      end
      do @(negedge aclk); while (!s_axi_bvalid);
      chk("bresp", s_axi_bresp, r);
      @(posedge aclk);
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic watch(input int e, input string n);
      int t = flips;
      while (flips < t + 3) @(posedge aclk);
      chk(n, gap, e);
      chk("pin b", sound_pin_b_o, !sound_pin_a_o);
      $display("%s done", n);
   endtask
   // c: channel two, 262k rate, fast source
   task automatic tone(input logic [6:0] s, input logic [1:0] p, input logic [2:0] c, int n);
      wr(12'hd9c, {p, p}, 2'h0);
      wr(12'hda0, {c[1], 1'h0, c[0]}, 2'h0);
      wr(c[2] ? 12'hd90 : 12'hd80, s[3:0], 2'h0);
      wr(c[2] ? 12'hd94 : 12'hd84, s[6:4], 2'h0);
      wr(12'hd98, c[2] ? 32'he : 32'hd, 2'h0);
      watch(n * (2 << p) * (c[0] ? (c[1] ? 8 : 16) : 1), "tone");
   endtask
   task automatic quiet;
      int t;
      wr(12'hd98, 1, 2'h0);
      repeat (4) @(posedge aclk);
      t = flips;
      repeat (40) @(posedge aclk);
      chk("quiet flips", flips - t, 0);
      $display("quiet done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #1ms;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      chk("gpio", {sound_pin_b_oe, sound_pin_a_oe, sound_pin_a_o, sound_pin_b_o}, 4'he);
      wr(12'hffc, 1, 2'h3);
      wr(12'hda4, 1, 2'h0);
      s_axi_araddr <= 12'hd98;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 0;
      do @(negedge aclk); while (!s_axi_rvalid);
      chk("read", s_axi_rdata | s_axi_rresp, 0);
      @(posedge aclk);
      s_axi_rready <= 0;
      tone(7'h40, 2'h0, 3'h0, 1);
      tone(7'h20, 2'h0, 3'h0, 122);
      tone(7'h40, 2'h3, 3'h0, 1);
      tone(7'h40, 2'h1, 3'h1, 1);
      tone(7'h40, 2'h0, 3'h7, 1);
      tone(7'h01, 2'h2, 3'h4, 127);
      quiet();
      wr(12'hd88, 0, 2'h0);
      wr(12'hda0, 2, 2'h0);
      watch(8, "alarm");
      wr(12'hda4, 0, 2'h0);
      chk("gpio", {sound_pin_a_oe, sound_pin_a_o, sound_pin_b_o}, 3'h6);
      print_verdict();
   end
endmodule
`default_nettype wire
